// ---- src/dpma_pkg.sv ----
package dpma_pkg;

   // Address width and data width of one port of the memory
   localparam int unsigned ADDR_W = 17;
   localparam int unsigned DATA_W = 8;

   // Mailbox locations: the left port owns 1FFFE, the right port owns 1FFFF
   localparam logic [16:0] MAILBOX_LEFT_ADDR  = 17'h1FFFE;
   localparam logic [16:0] MAILBOX_RIGHT_ADDR = 17'h1FFFF;

   // Semaphore flag select width and data bit that carries a flag write
   localparam int unsigned SEM_SEL_W   = 3;
   localparam int unsigned SEM_BIT_POS = 0;
   localparam logic [7:0]  SEM_REQUEST = 8'h00;
   localparam logic [7:0]  SEM_FREE    = 8'h01;

   // Clock rate and host-chosen pin timing
   localparam int unsigned CLK_PERIOD_NS = 40;
   // Setup also covers a master's collision pin crossing the synchroniser,
   // so a lost arbitration is seen before the write strobe starts
   localparam int unsigned SETUP_NS      = 120;  // Address and enable before any strobe
   localparam int unsigned STROBE_NS     = 80;   // Width of a write strobe
   localparam int unsigned SYNC_STAGES   = 2;    // Latency of the pin synchronisers
   localparam int unsigned SETUP_CYC  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Read strobe lasts long enough for returned data to clear the synchroniser
   localparam int unsigned READ_CYC   = STROBE_CYC + SYNC_STAGES;
   localparam int unsigned CNT_W      = 4;

   // Reset values of the port pins: everything deselected, bus released
   localparam logic        PIN_IDLE_N = 1'b1;
   localparam logic [16:0] ADDR_RST   = 17'h00000;
   localparam logic [7:0]  DATA_RST   = 8'h00;

   // Commands that the user side issues
   typedef enum logic [2:0] {
      OP_MEM_READ    = 3'h0,
      OP_MEM_WRITE   = 3'h1,
      OP_SEM_CLAIM   = 3'h2,
      OP_SEM_RELEASE = 3'h3,
      OP_SEM_READ    = 3'h4,
      OP_MAIL_SEND   = 3'h5,
      OP_MAIL_ACK    = 3'h6
   } dpma_op_t;

   // Sequencer states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE    = 4'h1,
      ST_SETUP   = 4'h2,
      ST_STROBE  = 4'h4,
      ST_RELEASE = 4'h8
   } dpma_state_t;

   // One request from the user side
   typedef struct packed {
      dpma_op_t    op;
      logic [16:0] addr;
      logic [7:0]  data;
   } dpma_req_t;

   // One answer to the user side
   typedef struct packed {
      logic [7:0] data;
      logic       granted;
      logic       collided;
   } dpma_rsp_t;

   // Pins that the host drives toward its memory port
   typedef struct packed {
      logic        chip_enable_n;
      logic        output_enable_n;
      logic        read_write_n;
      logic        semaphore_select_n;
      logic [16:0] addr;
      logic [7:0]  dq_out;
      logic        dq_oe;
   } dpma_pins_t;

endpackage

// ---- src/dpma_sync.sv ----
`timescale 1ns/100ps
// Two-flop synchroniser for pin inputs; the first stage feeds only the second
module dpma_sync #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   // Asynchronous level in, synchronous level out
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_q;

   // Both stages reset to a constant
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         meta_q <= RST_VAL;
         q      <= RST_VAL;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule

// ---- src/dpma_host.sv ----
`timescale 1ns/100ps
// How it works
// R1: Right host writing 1FFFE with enable and write strobe low raises left mailbox flag.
// R2: Left host clears its flag by accessing 1FFFE with enable and output enable low.
// R3: Left host writing 1FFFF raises the right mailbox flag.
// R4: Right host clears its flag by reading 1FFFF.
// R5: Mailbox byte is ordinary memory content, passed through unchanged.
// R6: Without mailbox use, 1FFFE and 1FFFF are plain memory locations.
// R7: Master memory flags same-location collisions toward the later port.
// R8: Memory blocks writes from the port seeing the collision flag.
// R9: Slave-mode memory treats each collision pin only as write inhibit.
// R10: In slave mode host drives collision high for writes, low to inhibit.
// R11: Depth-stacked parts need collision flags ANDed externally per port.
// R12: Width-expanded arrays use exactly one master; others are slaves.
// R13: Master arbitration uses enables and addresses only, not read or write.
// R14: Host holds address and enable valid before starting any strobe.
// R15: Memory offers eight semaphore flags apart from the array.
// R16: Ports are independent; only same-location write conflicts matter.
// R17: Port rests in standby with memory and semaphore enables both high.
// R18: Semaphore flags gate nothing; software interprets ownership.
// R19: Semaphore accesses finish as ordinary cycles with no waits.
// R20: Write zero on bit 0 requests a token, one releases it.
// R21: Semaphore flag picked by the three lowest address bits only.
// R22: A pending losing request gets the token when the owner releases.
// R23: Master never drives both collision flags low together.
module dpma_host #(
   parameter bit PORT_IS_LEFT = 1'b1
) (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst,
   // Configuration
   input  wire logic              master_mode,
   input  wire logic              write_inhibit,
   // User request
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire dpma_pkg::dpma_req_t req,
   // User answer and mailbox status
   output logic                   rsp_valid,
   output dpma_pkg::dpma_rsp_t    rsp,
   output logic                   mailbox_pending,
   // Memory port pins
   output dpma_pkg::dpma_pins_t   pins,
   input  wire logic [7:0]        dq_in,
   input  wire logic              mailbox_irq_n,
   input  wire logic              collision_n_in,
   output logic                   collision_n_out,
   output logic                   collision_n_oe
);

   // Whole state of the sequencer
   typedef struct packed {
      dpma_pkg::dpma_state_t st;
      logic [3:0]            cnt;
      dpma_pkg::dpma_op_t    op;
      logic                  phase;
      dpma_pkg::dpma_pins_t  pins;
      dpma_pkg::dpma_rsp_t   rsp;
      logic                  rsp_valid;
      logic                  coll_out_n;
   } dpma_host_state_t;

   dpma_host_state_t s_q;
   dpma_host_state_t s_d;
   logic [7:0]       dq_sync;
   logic             irq_sync_n;
   logic             coll_sync_n;

   // Every pin from the memory passes two flops first; stacked parts share one
   // externally ANDed collision pin, so a single input serves the whole array
   dpma_sync #(.WIDTH(10), .RST_VAL(10'h3FF)) u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .d       ({dq_in, mailbox_irq_n, collision_n_in}),                 // [R11]
      .q       ({dq_sync, irq_sync_n, coll_sync_n})
   );

   // True when this phase of the command drives data onto the port
   function automatic logic op_is_write(input dpma_pkg::dpma_op_t op, input logic phase);
      case (op)
         dpma_pkg::OP_MEM_WRITE,
         dpma_pkg::OP_MAIL_SEND,
         dpma_pkg::OP_SEM_RELEASE: op_is_write = 1'b1;
         dpma_pkg::OP_SEM_CLAIM:   op_is_write = ~phase;
         default:                  op_is_write = 1'b0;
      endcase
   endfunction

   // True for commands that address the semaphore space
   function automatic logic op_is_sem(input dpma_pkg::dpma_op_t op);
      op_is_sem = (op == dpma_pkg::OP_SEM_CLAIM) || (op == dpma_pkg::OP_SEM_RELEASE)
                  || (op == dpma_pkg::OP_SEM_READ);
   endfunction

   // Next state of the sequencer
   always_comb begin
      s_d           = s_q;
      s_d.rsp_valid = 1'b0;
      // Slave mode: pin high lets writes through, low inhibits them
      s_d.coll_out_n = ~write_inhibit;                                   // [R10] [R9]
      case (s_q.st)
         dpma_pkg::ST_IDLE: begin
            // Both enables high keeps the port in standby
            s_d.pins.chip_enable_n      = dpma_pkg::PIN_IDLE_N;          // [R17]
            s_d.pins.semaphore_select_n = dpma_pkg::PIN_IDLE_N;          // [R17]
            s_d.pins.output_enable_n    = dpma_pkg::PIN_IDLE_N;
            s_d.pins.read_write_n       = dpma_pkg::PIN_IDLE_N;
            s_d.pins.dq_oe              = 1'b0;
            if (req_valid) begin
               s_d.op           = req.op;
               s_d.phase        = 1'b0;
               s_d.cnt          = '0;
               s_d.rsp          = '0;
               s_d.pins.addr    = req.addr;                              // [R6]
               s_d.pins.dq_out  = req.data;                              // [R5]
               case (req.op)
                  dpma_pkg::OP_MAIL_SEND:                                // [R1] [R3]
                     s_d.pins.addr = PORT_IS_LEFT ? dpma_pkg::MAILBOX_RIGHT_ADDR
                                                  : dpma_pkg::MAILBOX_LEFT_ADDR;
                  dpma_pkg::OP_MAIL_ACK:                                 // [R2] [R4]
                     s_d.pins.addr = PORT_IS_LEFT ? dpma_pkg::MAILBOX_LEFT_ADDR
                                                  : dpma_pkg::MAILBOX_RIGHT_ADDR;
                  dpma_pkg::OP_SEM_CLAIM:
                     s_d.pins.dq_out = dpma_pkg::SEM_REQUEST;            // [R20]
                  dpma_pkg::OP_SEM_RELEASE:
                     s_d.pins.dq_out = dpma_pkg::SEM_FREE;               // [R20]
                  default: ;
               endcase
               if (op_is_sem(req.op)) begin
                  // Upper bits are ignored by the memory; drive them low anyway
                  s_d.pins.addr = {14'h0000, req.addr[dpma_pkg::SEM_SEL_W-1:0]}; // [R21]
                  s_d.pins.semaphore_select_n = 1'b0;                    // [R15]
               end else begin
                  s_d.pins.chip_enable_n = 1'b0;
               end
               s_d.pins.dq_oe = op_is_write(req.op, 1'b0);
               s_d.st         = dpma_pkg::ST_SETUP;
            end
         end
         dpma_pkg::ST_SETUP: begin
            // Address and enable stand still before the strobe
            s_d.cnt = s_q.cnt + 4'h1;                                    // [R14]
            if (master_mode && !op_is_sem(s_q.op) && !coll_sync_n) begin
               // Lost arbitration: hold the access and wait for the other port
               s_d.cnt          = '0;                                    // [R7] [R8]
               s_d.rsp.collided = 1'b1;
            end else if (s_q.cnt == 4'(dpma_pkg::SETUP_CYC - 1)) begin
               s_d.cnt = '0;
               s_d.st  = dpma_pkg::ST_STROBE;
               if (op_is_write(s_q.op, s_q.phase)) begin
                  s_d.pins.read_write_n = 1'b0;
               end else begin
                  s_d.pins.output_enable_n = 1'b0;                       // [R2] [R4]
               end
            end
         end
         dpma_pkg::ST_STROBE: begin
            s_d.cnt = s_q.cnt + 4'h1;
            if (op_is_write(s_q.op, s_q.phase)) begin
               if (s_q.cnt == 4'(dpma_pkg::STROBE_CYC - 1)) begin
                  s_d.pins.read_write_n = dpma_pkg::PIN_IDLE_N;
                  s_d.st                = dpma_pkg::ST_RELEASE;
               end
            end else if (s_q.cnt == 4'(dpma_pkg::READ_CYC - 1)) begin
               // Semaphore reads latch at the memory, so each read ends the cycle
               s_d.rsp.data             = dq_sync;
               s_d.rsp.granted          = ~dq_sync[dpma_pkg::SEM_BIT_POS]; // [R20]
               s_d.pins.output_enable_n = dpma_pkg::PIN_IDLE_N;
               s_d.st                   = dpma_pkg::ST_RELEASE;
            end
         end
         dpma_pkg::ST_RELEASE: begin
            s_d.pins.chip_enable_n      = dpma_pkg::PIN_IDLE_N;
            s_d.pins.semaphore_select_n = dpma_pkg::PIN_IDLE_N;
            s_d.pins.dq_oe              = 1'b0;
            s_d.cnt                     = '0;
            if (s_q.op == dpma_pkg::OP_SEM_CLAIM && !s_q.phase) begin
               // Write then read back: a pending request shows up as a one
               s_d.phase                   = 1'b1;                       // [R22] [R19]
               s_d.pins.semaphore_select_n = 1'b0;
               s_d.st                      = dpma_pkg::ST_SETUP;
            end else begin
               s_d.rsp_valid = 1'b1;
               s_d.st        = dpma_pkg::ST_IDLE;
            end
         end
         default: begin
            s_d.st = dpma_pkg::ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_q                         <= '0;
         s_q.st                      <= dpma_pkg::ST_IDLE;
         s_q.op                      <= dpma_pkg::OP_MEM_READ;
         s_q.pins.chip_enable_n      <= dpma_pkg::PIN_IDLE_N;
         s_q.pins.output_enable_n    <= dpma_pkg::PIN_IDLE_N;
         s_q.pins.read_write_n       <= dpma_pkg::PIN_IDLE_N;
         s_q.pins.semaphore_select_n <= dpma_pkg::PIN_IDLE_N;
         s_q.pins.addr               <= dpma_pkg::ADDR_RST;
         s_q.pins.dq_out             <= dpma_pkg::DATA_RST;
         s_q.coll_out_n              <= dpma_pkg::PIN_IDLE_N;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs
   assign req_ready       = (s_q.st == dpma_pkg::ST_IDLE);
   assign rsp_valid       = s_q.rsp_valid;
   assign rsp             = s_q.rsp;
   assign pins            = s_q.pins;
   assign mailbox_pending = ~irq_sync_n;
   // Master drives the pin itself; only a slave gets our inhibit level
   assign collision_n_out = s_q.coll_out_n;
   assign collision_n_oe  = ~master_mode;                                // [R9] [R12]

endmodule

// ---- verif/dpma_host_sva.sv ----
`timescale 1ns/100ps
// Port-side checks of one host sequencer
module dpma_host_sva #(
   parameter bit PORT_IS_LEFT = 1'b1
) (
   // Clock and reset
   input wire logic                 clk_sys,
   input wire logic                 rst,
   // Configuration and user side
   input wire logic                 master_mode,
   input wire logic                 write_inhibit,
   input wire logic                 req_valid,
   input wire logic                 req_ready,
   input wire dpma_pkg::dpma_req_t  req,
   input wire logic                 rsp_valid,
   input wire logic                 mailbox_pending,
   // Memory port pins
   input wire dpma_pkg::dpma_pins_t pins,
   input wire logic                 mailbox_irq_n,
   input wire logic                 collision_n_out,
   input wire logic                 collision_n_oe
);
   localparam logic [16:0] PEER_BOX = PORT_IS_LEFT ? 17'h1FFFF : 17'h1FFFE;
   localparam logic [16:0] OWN_BOX  = PORT_IS_LEFT ? 17'h1FFFE : 17'h1FFFF;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic taken;
   // A request is taken when both sides agree
   assign taken = req_valid && req_ready;
   // Setup with strobe high first, so arbitration settles before any write
   sequence s_write;
      (!pins.chip_enable_n && pins.read_write_n)[*3] ##1 !pins.read_write_n[*2]
      ##1 (pins.read_write_n && !pins.chip_enable_n) ##1 (pins.chip_enable_n && rsp_valid);
   endsequence
   sequence s_read;
      (!pins.chip_enable_n && pins.output_enable_n)[*3] ##1 !pins.output_enable_n[*4]
      ##1 (pins.output_enable_n && !pins.chip_enable_n) ##1 (pins.chip_enable_n && rsp_valid);
   endsequence
   chk_write_walk: assert property (
      taken && req.op == dpma_pkg::OP_MEM_WRITE && !master_mode |=> s_write)
      else $error("write cycle shape wrong");
   chk_read_walk: assert property (
      taken && req.op == dpma_pkg::OP_MEM_READ && !master_mode |=> s_read)
      else $error("read cycle shape wrong");
   chk_idle_standby: assert property (
      req_ready |-> pins.chip_enable_n && pins.semaphore_select_n)
      else $error("idle port not in standby");
   chk_sem_addr: assert property (
      !pins.semaphore_select_n |-> pins.addr[16:3] == 14'h0000 && pins.chip_enable_n)
      else $error("semaphore address wrong");
   chk_sem_claim: assert property (
      taken && req.op == dpma_pkg::OP_SEM_CLAIM
      |=> (!pins.semaphore_select_n && !pins.dq_out[0]) ##14 rsp_valid)
      else $error("claim cycle wrong");
   chk_sem_free: assert property (
      taken && req.op == dpma_pkg::OP_SEM_RELEASE
      |=> !pins.semaphore_select_n && pins.dq_out[0])
      else $error("release data wrong");
   chk_mail_send: assert property (
      taken && req.op == dpma_pkg::OP_MAIL_SEND
      |=> pins.addr == PEER_BOX && pins.dq_out == $past(req.data))
      else $error("mail send wrong");
   chk_mail_ack: assert property (
      taken && req.op == dpma_pkg::OP_MAIL_ACK && !master_mode
      |=> pins.addr == OWN_BOX ##3 !pins.output_enable_n)
      else $error("mail ack wrong");
   chk_mail_seen: assert property (
      $fell(mailbox_irq_n) |-> ##[1:3] mailbox_pending)
      else $error("pending flag late");
   chk_inhibit_pin: assert property (
      collision_n_out == !$past(write_inhibit))
      else $error("inhibit pin wrong");
   chk_pin_dir: assert property (
      collision_n_oe == !master_mode)
      else $error("collision pin direction wrong");
endmodule
bind dpma_host dpma_host_sva #(.PORT_IS_LEFT(PORT_IS_LEFT)) i_dpma_host_sva (
   .clk_sys(clk_sys), .rst(rst), .master_mode(master_mode), .write_inhibit(write_inhibit),
   .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
   .mailbox_pending(mailbox_pending), .pins(pins), .mailbox_irq_n(mailbox_irq_n),
   .collision_n_out(collision_n_out), .collision_n_oe(collision_n_oe));

// ---- verif/dpma_mem_model.sv ----
`timescale 1ns/100ps
// Dual-port memory: left port on pins, right port through tasks
module dpma_mem_model (
   // Left port pins and data bus
   input  wire dpma_pkg::dpma_pins_t lp,
   input  wire logic [7:0]           dq_bus,
   output logic      [7:0]           l_dq,
   // Flags
   input  wire logic                 m_s,
   input  wire logic                 coll_pin,
   output logic                      busy_l_n,
   output logic                      l_irq_n,
   output logic                      r_irq_n
);
   logic [7:0]  mem [int];
   logic [7:0]  sem_lat = 8'hFF;
   logic [7:0]  l_last = 8'h00;
   logic [7:0]  req_l = 8'hFF;
   logic [7:0]  req_r = 8'hFF;
   int          own [8];  // 0 free, 1 left, 2 right
   logic        r_hold = 1'b0;
   logic [16:0] r_addr = 17'h00000;
   initial begin
      l_irq_n = 1'b1;
      r_irq_n = 1'b1;
   end
   // Right port held first, so only the left port can lose
   // One part only, so the external AND of a stacked array is this pin alone
   assign busy_l_n = !(m_s && r_hold && !lp.chip_enable_n && lp.addr == r_addr);
   // Request latches; a pending request takes over on release, no waits
   function automatic void resolve(input int k);
      if (own[k] == 1 && req_l[k]) own[k] = req_r[k] ? 0 : 2;
      else if (own[k] == 2 && req_r[k]) own[k] = req_l[k] ? 0 : 1;
      if (own[k] == 0) own[k] = !req_l[k] ? 1 : (!req_r[k] ? 2 : 0);
   endfunction
   // Writes land at the end of the strobe, only with the collision pin high; semaphore flags gate nothing
   always @(posedge lp.read_write_n) begin
      if (!lp.chip_enable_n && coll_pin === 1'b1) begin
         mem[lp.addr] = dq_bus;
         if (lp.addr == 17'h1FFFF) r_irq_n = 1'b0;
      end
      if (!lp.semaphore_select_n) begin
         req_l[lp.addr[2:0]] = dq_bus[0];
         resolve(lp.addr[2:0]);
      end
   end
   // Own mailbox access clears the flag only while output enable is low
   always @(*) begin
      if (!lp.chip_enable_n && !lp.output_enable_n && lp.addr == 17'h1FFFE) l_irq_n = 1'b1;
   end
   // Flag latched when the read begins, so it cannot change mid-read
   always @(negedge lp.output_enable_n) sem_lat = {8{own[lp.addr[2:0]] != 1}};
   always @(posedge lp.output_enable_n) l_last = l_dq;
   // Released bus shows the inverse of the last byte, not a stale copy
   always @(*) begin
      if (!lp.output_enable_n && !lp.semaphore_select_n) l_dq = sem_lat;
      else if (!lp.output_enable_n && !lp.chip_enable_n) l_dq = mem[lp.addr];
      else l_dq = ~l_last;
   end
   // Right port, served apart from the left
   task automatic right_write(input logic [16:0] a, input logic [7:0] d);
      mem[a] = d;
      if (a == 17'h1FFFE) l_irq_n = 1'b0;
   endtask
   task automatic right_read(input logic [16:0] a, output logic [7:0] d);
      d = mem[a];
      if (a == 17'h1FFFF) r_irq_n = 1'b1;
   endtask
   task automatic right_sem(input int k, input logic v);
      req_r[k] = v;
      resolve(k);
   endtask
endmodule

// ---- verif/dpma_host_test.sv ----
`timescale 1ns/100ps
module dpma_host_test;
   logic                 clk_sys = 1'b0;
   logic                 rst = 1'b1;
   logic                 master_mode = 1'b0;
   logic                 write_inhibit = 1'b0;
   logic                 req_valid = 1'b0;
   dpma_pkg::dpma_req_t  req = '0;
   dpma_pkg::dpma_rsp_t  rsp;
   dpma_pkg::dpma_pins_t pins;
   logic                 req_ready, rsp_valid, pending, irq_l_n, irq_r_n, busy_n, c_out, c_oe;
   logic [7:0]           mem_dq, d;
   logic [16:0]          a;
   logic [7:0]           exp_mem [int];
   logic [16:0]          aq [$];
   int                   err_total = 0, num_checks = 0, seed = 68, i, k;
   wire logic [7:0]      dq_bus = pins.dq_oe ? pins.dq_out : mem_dq;
   wire logic            coll_pin = c_oe ? c_out : busy_n;
   always #20 clk_sys = ~clk_sys;
   dpma_host #(.PORT_IS_LEFT(1'b1)) i_dpma_host (.clk_sys(clk_sys), .rst(rst),
      .master_mode(master_mode), .write_inhibit(write_inhibit), .req_valid(req_valid),
      .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp(rsp),
      .mailbox_pending(pending), .pins(pins), .dq_in(dq_bus), .mailbox_irq_n(irq_l_n),
      .collision_n_in(coll_pin), .collision_n_out(c_out), .collision_n_oe(c_oe));
   dpma_mem_model i_mem (.lp(pins), .dq_bus(dq_bus), .l_dq(mem_dq), .m_s(master_mode),
      .coll_pin(coll_pin), .busy_l_n(busy_n), .l_irq_n(irq_l_n), .r_irq_n(irq_r_n));
   task automatic summarize;
      $display("Checks %0d, mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // One request, held for the take edge, then a bounded wait for the answer
   task automatic op(input dpma_pkg::dpma_op_t o, input logic [16:0] ad, input logic [7:0] v);
      int n;
      n = 0;
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req <= '{o, ad, v};
      @(posedge clk_sys);
      req_valid <= 1'b0;
      do begin
         @(posedge clk_sys);
         #1;
         n++;
      end while (rsp_valid !== 1'b1 && n < 200);
      if (n >= 200) chk(8'h00, 8'h01, "no response");
   endtask
   // Hang guard of 10000 cycles, far beyond the expected few hundred cycles
   initial begin
      #400000;
      err_total++;
      summarize();
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      aq.push_back(17'h1FFFE);
      for (i = 0; i < 6; i++) aq.push_back(17'($random(seed)) & 17'h0FFFF);
      foreach (aq[i]) begin
         d = 8'($random(seed));
         op(dpma_pkg::OP_MEM_WRITE, aq[i], d);
         exp_mem[aq[i]] = d;
      end
      foreach (aq[i]) begin
         op(dpma_pkg::OP_MEM_READ, aq[i], 8'h00);
         chk(rsp.data, exp_mem[aq[i]], "memory read");
      end
      // Mailboxes in both directions
      op(dpma_pkg::OP_MAIL_SEND, 17'h00000, 8'h5A);
      chk(8'(irq_r_n), 8'h00, "right flag set");
      i_mem.right_read(17'h1FFFF, d);
      chk(d, 8'h5A, "right mail byte");
      chk(8'(irq_r_n), 8'h01, "right flag clear");
      i_mem.right_write(17'h1FFFE, 8'hC3);
      exp_mem[17'h1FFFE] = 8'hC3;
      repeat (4) @(posedge clk_sys);
      #1;
      chk(8'(pending), 8'h01, "left pending");
      op(dpma_pkg::OP_MAIL_ACK, 17'h00000, 8'h00);
      chk(rsp.data, 8'hC3, "left mail byte");
      chk(8'(pending), 8'h00, "left pending clear");
      // Every flag, with junk in the high address bits
      for (k = 0; k < 8; k++) begin
         a = (17'($random(seed)) & 17'h1FFF8) | 17'(k);
         op(dpma_pkg::OP_SEM_CLAIM, a, 8'h00);
         chk(8'(rsp.granted), 8'h01, "free flag claimed");
         op(dpma_pkg::OP_SEM_RELEASE, a, 8'h01);
      end
      i_mem.right_sem(3, 1'b0);
      op(dpma_pkg::OP_SEM_CLAIM, 17'h00003, 8'h00);
      chk(8'(rsp.granted), 8'h00, "owned flag refused");
      op(dpma_pkg::OP_MEM_READ, aq[0], 8'h00);
      chk(rsp.data, exp_mem[aq[0]], "read with foreign token");
      i_mem.right_sem(3, 1'b1);
      op(dpma_pkg::OP_SEM_READ, 17'h00003, 8'h00);
      chk(8'(rsp.granted), 8'h01, "pending claim handed over");
      op(dpma_pkg::OP_SEM_RELEASE, 17'h00003, 8'h01);
      // Slave mode: inhibited write leaves the byte alone
      write_inhibit <= 1'b1;
      op(dpma_pkg::OP_MEM_WRITE, aq[1], ~exp_mem[aq[1]]);
      write_inhibit <= 1'b0;
      op(dpma_pkg::OP_MEM_READ, aq[1], 8'h00);
      chk(rsp.data, exp_mem[aq[1]], "inhibited write");
      // Master mode: right port holds the location, left write then read collide
      master_mode <= 1'b1;
      i_mem.r_addr = aq[2];
      for (i = 0; i < 2; i++) begin
         i_mem.r_hold = 1'b1;
         fork
            op(i ? dpma_pkg::OP_MEM_READ : dpma_pkg::OP_MEM_WRITE, aq[2], 8'h3C);
            begin
               repeat (12) @(posedge clk_sys);
               i_mem.r_hold <= 1'b0;
            end
         join
         chk(8'(rsp.collided), 8'h01, "collision seen");
      end
      chk(rsp.data, 8'h3C, "write after collision");
      master_mode <= 1'b0;
      summarize();
   end
endmodule
